//--- design/mia_host.sv
// host controller issuing ip authentication commands to the identity card
//
// Functional notes
// (R1) chain home-agent data, at most 254 per block
// (R2) card flags home-agent chaining errors with 98 34
// (R3) class 80, instruction 80, parameter 1 = 01
// (R4) parameter 2 gives first, next, single, last
// (R5) home-agent expects 0 or 16 response bytes
// (R6) slot octet leads first and single blocks
// (R7) card picks home-agent secret from slot
// (R8) card answers 16 bytes only on end blocks
// (R9) card hashes secret, message, secret again
// (R10) card joins block data in arrival order
// (R11) hash defaults to md5, operator may change
// (R12) request hash: parameter 1 = 02, no response
// (R13) card flags hash chaining errors with 98 34
// (R14) end hash blocks append 8-byte extension header
// (R15) hash data: 255 mid, 247 end block
// (R16) card hashes request data, keeps result inside
// (R17) server auth: 03, 00, 16-byte answer
// (R18) server auth: slot octet then challenge bytes
// (R19) long challenge: top byte plus last 237
// (R20) card uses short challenge unpadded
// (R21) card hashes top byte, secret, hash, tail
// (R22) order: home-agent, hash, server auth
// (R23) sequence error drops partial state, restart
`timescale 1ns/10ps
`include "mia_regs.svh"
module mia_host
	import mia_pkg::*;
(
	input wire logic clock, // system clock
	input wire logic nrst, // async reset, low
	input wire logic job_valid, // user job request
	output logic job_ready, // controller idle
	input mia_job_s job, // option, slot, data length
	input wire logic in_valid, // user data byte valid
	output logic in_ready, // user data accepted
	input wire logic [7:0] in_data, // user data byte
	output logic out_valid, // authenticator byte valid
	output logic [7:0] out_data, // authenticator byte
	output logic done_valid, // job finished pulse
	output mia_done_s done, // job result
	output logic cmd_valid, // command header valid
	input wire logic cmd_ready, // card took header
	output mia_cmd_s cmd, // command header
	output logic tx_valid, // command data byte valid
	input wire logic tx_ready, // card took data byte
	output logic [7:0] tx_data, // command data byte
	input wire logic rsp_valid, // response byte from card
	input wire logic [7:0] rsp_data, // response byte
	input wire logic sw_valid, // status words from card
	input wire logic [7:0] sw1, // status word 1
	input wire logic [7:0] sw2 // status word 2
);
	typedef enum logic [5:0] {
		S_IDLE = 6'b000001,
		S_PLAN = 6'b000010,
		S_HDR = 6'b000100,
		S_DATA = 6'b001000,
		S_WAIT = 6'b010000,
		S_DRAIN = 6'b100000
	} mia_state_e;

	mia_state_e state_q;
	mia_seq_e seq_q;
	mia_opt_e opt_q;
	mia_cmd_s cmd_q;
	mia_done_s done_q;
	mia_plan_s plan;
	logic [7:0] slot_q;
	logic [15:0] len_q;
	logic [15:0] rem_q;
	logic [15:0] take_q;
	logic [15:0] cnt_q;
	logic [15:0] drain_q;
	logic first_q;
	logic last_q;
	logic slot_pend_q;
	logic done_valid_q;
	logic out_valid_q;
	logic [7:0] out_data_q;
	logic f_valid;
	logic f_ready;
	logic [7:0] f_data;

	////////////////////////////////////////////////////////////////////////
	// user data buffer and block planning

	mia_fifo #(
		.WIDTH(8),
		.DEPTH(`MIA_FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.nrst(nrst),
		.in_valid(in_valid),
		.in_ready(in_ready),
		.in_data(in_data),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_data)
	);

	mia_block_plan u_plan (
		.opt(opt_q),
		.first(first_q),
		.rem(rem_q),
		.plan(plan)
	);

	////////////////////////////////////////////////////////////////////////
	// decode

	wire in_data_st = state_q == S_DATA;
	wire blk_end = !slot_pend_q && cnt_q == take_q;
	wire [15:0] aaa_cut = (len_q > `MIA_AAA_KEEP) ?
		16'(len_q - `MIA_AAA_TAIL) : 16'h0000;
	// middle of an over-long challenge is read and thrown away
	wire drop = opt_q == OPT_AAA && cnt_q != 16'h0000 && cnt_q < aaa_cut; // R19
	wire data_pop = in_data_st && !slot_pend_q && !blk_end &&
		(drop || tx_ready);
	wire drain_pop = state_q == S_DRAIN && drain_q != 16'h0000;
	wire consume = f_ready && f_valid;
	wire sw_seq = sw1 == `MIA_SW1_SEQ && sw2 == `MIA_SW2_SEQ; // R2 R13
	wire sw_ok = sw1 == `MIA_SW1_OK && sw2 == `MIA_SW2_OK;
	wire job_fire = job_valid && job_ready;
	wire job_legal = job.opt == OPT_HA || // R22
		(job.opt == OPT_HASH && seq_q != SEQ_NONE) ||
		(job.opt == OPT_AAA && seq_q == SEQ_HASH);
	wire [15:0] job_bytes = (job.opt == OPT_HASH) ?
		16'(job.len + `MIA_HASH_HDR) : job.len;
	wire [15:0] left_bytes = (opt_q == OPT_HASH && !last_q) ?
		16'(rem_q + `MIA_HASH_HDR) : rem_q;
	wire ok_end = state_q == S_WAIT && sw_valid && sw_ok && last_q;

	assign job_ready = state_q == S_IDLE;
	assign cmd_valid = state_q == S_HDR;
	assign cmd = cmd_q;
	assign tx_valid = in_data_st && (slot_pend_q || (f_valid && !drop &&
		!blk_end));
	assign tx_data = slot_pend_q ? slot_q : f_data; // R6 R18
	assign f_ready = data_pop || drain_pop;
	assign done_valid = done_valid_q;
	assign done = done_q;
	assign out_valid = out_valid_q;
	assign out_data = out_data_q;

	////////////////////////////////////////////////////////////////////////
	// sequencer

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_q <= S_IDLE;
			seq_q <= SEQ_NONE;
			opt_q <= OPT_HA;
			slot_q <= 8'h00;
			len_q <= 16'h0000;
			rem_q <= 16'h0000;
			first_q <= 1'b1;
			drain_q <= 16'h0000;
			done_q <= '0;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (job_fire) begin
						opt_q <= job.opt;
						slot_q <= job.slot;
						len_q <= job.len;
						rem_q <= job.len;
						first_q <= 1'b1;
						drain_q <= job_bytes;
						done_q.code <= job_legal ? CODE_OK : CODE_ORDER; // R22
						state_q <= job_legal ? S_PLAN : S_DRAIN;
					end
				end
				S_PLAN: begin
					state_q <= S_HDR;
				end
				S_HDR: begin
					if (cmd_ready) begin
						rem_q <= last_q ? 16'h0000 : 16'(rem_q - take_q); // R1
						state_q <= S_DATA;
					end
				end
				S_DATA: begin
					if (blk_end) begin
						state_q <= S_WAIT;
					end
				end
				S_WAIT: begin
					if (sw_valid) begin
						done_q.sw1 <= sw1;
						done_q.sw2 <= sw2;
						drain_q <= left_bytes;
						if (sw_ok && !last_q) begin
							first_q <= 1'b0; // R4
							state_q <= S_PLAN;
						end else if (sw_ok) begin
							state_q <= S_IDLE;
							seq_q <= (opt_q == OPT_HA) ? SEQ_HA : // R22
								(opt_q == OPT_HASH) ? SEQ_HASH : SEQ_NONE;
						end else begin
							// partial chain is abandoned, user stream kept aligned
							done_q.code <= sw_seq ? CODE_SEQ : CODE_CARD; // R23
							seq_q <= SEQ_NONE; // R23
							state_q <= S_DRAIN;
						end
					end
				end
				S_DRAIN: begin
					if (drain_q == 16'h0000) begin
						state_q <= S_IDLE;
					end else if (consume) begin
						drain_q <= 16'(drain_q - 16'h0001);
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cmd_q <= '0;
			take_q <= 16'h0000;
			last_q <= 1'b0;
			slot_pend_q <= 1'b0;
			cnt_q <= 16'h0000;
		end else if (state_q == S_PLAN) begin
			cmd_q <= plan.cmd; // R3 R4 R5
			take_q <= plan.take;
			last_q <= plan.last;
			slot_pend_q <= plan.slot;
			cnt_q <= 16'h0000;
		end else if (in_data_st) begin
			if (slot_pend_q && tx_ready) begin
				slot_pend_q <= 1'b0;
			end
			if (data_pop && f_valid) begin
				cnt_q <= 16'(cnt_q + 16'h0001);
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			out_valid_q <= 1'b0;
			out_data_q <= 8'h00;
			done_valid_q <= 1'b0;
		end else begin
			out_valid_q <= state_q == S_WAIT && rsp_valid; // R5
			if (state_q == S_WAIT && rsp_valid) begin
				out_data_q <= rsp_data;
			end
			done_valid_q <= ok_end ||
				(state_q == S_DRAIN && drain_q == 16'h0000);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	wire cmd_fire = cmd_valid && cmd_ready;

	a_cls_ins_fixed: assert property (cmd_valid |-> // R3
		cmd.cla == `MIA_CLA && cmd.ins == `MIA_INS)
		else $error("class or instruction byte wrong");
	a_ha_blk_max: assert property (cmd_valid && cmd.p1 == `MIA_P1_HA |-> // R1
		(cmd.p2[1] || cmd.lc >= 8'hFE) &&
		(cmd.p2[0] ? cmd.lc <= 8'hFE : cmd.lc >= 8'h01))
		else $error("home-agent block size out of range");
	a_ha_p2_code: assert property (cmd_valid && cmd.p1 != `MIA_P1_AAA |-> // R4
		cmd.p2 <= `MIA_P2_LAST && (cmd.p2[0] == !first_q))
		else $error("chaining code does not match position");
	a_ha_le_len: assert property (cmd_valid && cmd.p1 == `MIA_P1_HA |-> // R5
		cmd.le == (cmd.p2[1] ? `MIA_LE_AUTH : `MIA_LE_NONE))
		else $error("home-agent response length wrong");
	a_slot_leads: assert property (cmd_fire && cmd.p1 != `MIA_P1_HASH && // R6
		first_q |=> tx_valid && tx_data == slot_q)
		else $error("slot octet not sent first");
	a_hash_p1_le: assert property (cmd_valid && opt_q == OPT_HASH |-> // R12
		cmd.p1 == `MIA_P1_HASH && cmd.le == `MIA_LE_NONE)
		else $error("hash command header wrong");
	a_hash_blk_len: assert property (cmd_valid && opt_q == OPT_HASH |-> // R14
		(cmd.p2[1] ? cmd.lc >= 8'h08 : cmd.lc > 8'hF7))
		else $error("hash block length wrong");
	a_aaa_cmd_hdr: assert property (cmd_valid && opt_q == OPT_AAA |-> // R17
		cmd.p1 == `MIA_P1_AAA && cmd.p2 == `MIA_P2_FIRST &&
		cmd.le == `MIA_LE_AUTH && cmd.lc <= 8'hEF)
		else $error("server auth header wrong");
	a_order_kept: assert property (cmd_valid && first_q && // R22
		opt_q == OPT_AAA |-> seq_q == SEQ_HASH)
		else $error("server auth issued out of order");
	a_seq_discard: assert property (state_q == S_WAIT && sw_valid && // R23
		sw_seq |=> seq_q == SEQ_NONE && state_q == S_DRAIN)
		else $error("sequence error did not discard state");

	c_ha_chain: cover property (cmd_fire && cmd.p2 == `MIA_P2_LAST);
	c_aaa_drop: cover property (in_data_st && drop && consume);
	c_seq_err: cover property (done_valid && done.code == CODE_SEQ);
	c_order_ref: cover property (done_valid && done.code == CODE_ORDER);
endmodule

//--- design/mia_regs.svh
// command codes, field limits and status words of the ip authentication link
`ifndef MIA_REGS_SVH
`define MIA_REGS_SVH
`define MIA_CLA 8'h80
`define MIA_INS 8'h80
`define MIA_P1_HA 8'h01
`define MIA_P1_HASH 8'h02
`define MIA_P1_AAA 8'h03
`define MIA_P2_FIRST 8'h00
`define MIA_P2_NEXT 8'h01
`define MIA_P2_SINGLE 8'h02
`define MIA_P2_LAST 8'h03
`define MIA_LE_NONE 8'h00
`define MIA_LE_AUTH 8'h10
`define MIA_HA_MAX 16'h00FE
`define MIA_HASH_MID_MAX 16'h00FF
`define MIA_HASH_LAST_MAX 16'h00F7
`define MIA_HASH_HDR 16'h0008
`define MIA_AAA_TAIL 16'h00ED
`define MIA_AAA_KEEP 16'h00EE
`define MIA_SW1_SEQ 8'h98
`define MIA_SW2_SEQ 8'h34
`define MIA_SW1_OK 8'h90
`define MIA_SW2_OK 8'h00
`define MIA_FIFO_DEPTH 4
`endif

//--- design/mia_pkg.sv
// types shared by the ip authentication host controller
package mia_pkg;
	typedef enum logic [1:0] {
		OPT_HA = 2'h1,
		OPT_HASH = 2'h2,
		OPT_AAA = 2'h3
	} mia_opt_e;
	typedef enum logic [2:0] {
		SEQ_NONE = 3'b001,
		SEQ_HA = 3'b010,
		SEQ_HASH = 3'b100
	} mia_seq_e;
	typedef enum logic [1:0] {
		CODE_OK = 2'h0,
		CODE_SEQ = 2'h1,
		CODE_ORDER = 2'h2,
		CODE_CARD = 2'h3
	} mia_code_e;
	typedef struct packed {
		logic [7:0] cla;
		logic [7:0] ins;
		logic [7:0] p1;
		logic [7:0] p2;
		logic [7:0] lc;
		logic [7:0] le;
	} mia_cmd_s;
	typedef struct packed {
		mia_opt_e opt;
		logic [7:0] slot;
		logic [15:0] len;
	} mia_job_s;
	typedef struct packed {
		mia_code_e code;
		logic [7:0] sw1;
		logic [7:0] sw2;
	} mia_done_s;
	typedef struct packed {
		mia_cmd_s cmd;
		logic [15:0] take;
		logic last;
		logic slot;
	} mia_plan_s;
endpackage

//--- design/mia_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps
module mia_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clock, // system clock
	input wire logic nrst, // async reset, low
	input wire logic in_valid, // write request
	output logic in_ready, // not full
	input wire logic [WIDTH-1:0] in_data, // write data
	output logic out_valid, // not empty
	input wire logic out_ready, // read request
	output logic [WIDTH-1:0] out_data // head word
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = cnt_q != (AW+1)'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign out_data = mem_q[rp_q];

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= bump(wp_q);
			end
			if (pop) begin
				rp_q <= bump(rp_q);
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

//--- design/mia_block_plan.sv
// works out the header and byte count of the next command block
`timescale 1ns/10ps
`include "mia_regs.svh"
module mia_block_plan
	import mia_pkg::*;
(
	input mia_opt_e opt, // option of the running job
	input wire logic first, // no block sent yet
	input wire logic [15:0] rem, // user bytes still to send
	output mia_plan_s plan // header and block size
);
	wire ha_last = rem <= `MIA_HA_MAX;
	wire hs_last = rem <= `MIA_HASH_LAST_MAX;
	wire aaa_cut = rem >= `MIA_AAA_KEEP;
	wire [15:0] ha_take = ha_last ? rem : `MIA_HA_MAX;
	wire [15:0] hs_mid = (rem >= `MIA_HASH_MID_MAX) ? `MIA_HASH_MID_MAX : rem;
	wire [15:0] hs_take = hs_last ? 16'(rem + `MIA_HASH_HDR) : hs_mid;
	wire [15:0] aaa_lc = aaa_cut ? 16'(`MIA_AAA_KEEP + 16'h0001) :
		16'(rem + 16'h0001);
	wire last = (opt == OPT_AAA) || (opt == OPT_HA ? ha_last : hs_last);
	wire [7:0] p2_chain = first ? (last ? `MIA_P2_SINGLE : `MIA_P2_FIRST) :
		(last ? `MIA_P2_LAST : `MIA_P2_NEXT);

	assign plan.cmd.cla = `MIA_CLA; // R3
	assign plan.cmd.ins = `MIA_INS; // R3
	assign plan.cmd.p1 = (opt == OPT_HA) ? `MIA_P1_HA : // R3
		(opt == OPT_HASH) ? `MIA_P1_HASH : `MIA_P1_AAA; // R12 R17
	assign plan.cmd.p2 = (opt == OPT_AAA) ? `MIA_P2_FIRST : p2_chain; // R4
	// slot octet leads first and single blocks
	assign plan.cmd.lc = (opt == OPT_HA) ? 8'(ha_take + 16'(first)) : // R6
		(opt == OPT_HASH) ? hs_take[7:0] : aaa_lc[7:0]; // R14 R18
	assign plan.cmd.le = ((opt == OPT_HA && last) || opt == OPT_AAA) ?
		`MIA_LE_AUTH : `MIA_LE_NONE; // R5 R12 R17
	assign plan.take = (opt == OPT_HA) ? ha_take : // R1
		(opt == OPT_HASH) ? hs_take : rem; // R15
	assign plan.last = last;
	assign plan.slot = first && (opt != OPT_HASH); // R6 R18
endmodule

//--- verif/mia_card_model.sv
// behavioural identity card answering ip authentication commands
`timescale 1ns/10ps
`include "mia_regs.svh"
module mia_card_model
	import mia_pkg::*;
(
	input wire logic clock, // system clock
	input wire logic nrst, // async reset, low
	input wire logic cmd_valid, // header valid
	output logic cmd_ready, // header taken
	input mia_cmd_s cmd, // header
	input wire logic tx_valid, // data valid
	output logic tx_ready, // data taken
	input wire logic [7:0] tx_data, // data byte
	output logic rsp_valid, // response byte valid
	output logic [7:0] rsp_data, // response byte
	output logic sw_valid, // status valid
	output logic [7:0] sw1, // status word 1
	output logic [7:0] sw2, // status word 2
	input wire logic stall, // slow answers
	input wire logic force_err, // answer sequence error
	input wire logic fault, // answer another card error
	output int bad, // malformed headers
	output int blocks // headers taken
);
	mia_cmd_s h;
	logic [7:0] d[$];
	logic [7:0] acc, keep, sec;
	logic [1:0] seq, chain;
	logic endb, cont, ok;
	int k;
	localparam logic [7:0] FAULT_SW1 = 8'h6F; // arbitrary error status
////////////////////////////////////////
	function automatic logic [7:0] mix(logic [7:0] a, logic [7:0] b);
		return {a[6:0], a[7]} ^ b;
	endfunction

	task automatic status(input logic [7:0] a, input logic [7:0] b);
		repeat (stall ? 20 : 3) @(posedge clock);
		sw_valid <= 1'b1;
		sw1 <= a;
		sw2 <= b;
		@(posedge clock);
		sw_valid <= 1'b0;
		sw1 <= ~a;
		sw2 <= ~b;
	endtask

	task automatic reply(input logic [7:0] a);
		repeat (stall ? 20 : 3) @(posedge clock);
		for (int i = 0; i < 16; i++) begin
			rsp_valid <= 1'b1;
			rsp_data <= a + 8'(i);
			@(posedge clock);
		end
		rsp_valid <= 1'b0;
		rsp_data <= ~rsp_data;
	endtask

	task automatic serve();
		endb = h.p2[1];
		cont = h.p2[0];
		if (h.cla !== `MIA_CLA || h.ins !== `MIA_INS || h.p2 > 8'h03)
			bad++;
		if (h.le !== ((h.p1 == `MIA_P1_HA && endb || h.p1 == `MIA_P1_AAA) ?
			`MIA_LE_AUTH : `MIA_LE_NONE))
			bad++;
		if (h.p1 == `MIA_P1_HASH && endb && h.lc < 8'h08 ||
			h.p1 == `MIA_P1_HA && cont && h.lc > 8'hFE)
			bad++;
		case (h.p1)
			`MIA_P1_HA: ok = cont == (chain == 2'h1);
			`MIA_P1_HASH: ok = cont ? chain == 2'h2 : seq == 2'h1;
			`MIA_P1_AAA: ok = seq == 2'h2 && h.p2 == 8'h00;
			default: ok = 1'b0;
		endcase
		if (fault) begin
			chain = 2'h0;
			seq = 2'h0;
			status(FAULT_SW1, 8'h00);
			return;
		end
		if (!ok || force_err) begin
			chain = 2'h0;
			seq = 2'h0;
			status(`MIA_SW1_SEQ, `MIA_SW2_SEQ);
			return;
		end
		k = 0;
		if (h.p1 != `MIA_P1_HASH && !cont) begin
			sec = d[0] ^ (h.p1 == `MIA_P1_HA ? 8'h5A : 8'hA5);
			k = 1;
		end
		if (h.p1 == `MIA_P1_HASH && !cont)
			acc = 8'h00;
		if (h.p1 == `MIA_P1_HA && !cont)
			acc = sec;
		if (h.p1 == `MIA_P1_AAA) begin
			acc = mix(mix(d[1], sec), keep);
			k = d.size() == 239 ? 2 : 1;
		end
		for (int i = k; i < d.size(); i++)
			acc = mix(acc, d[i]);
		chain = endb || h.p1 == `MIA_P1_AAA ? 2'h0 : h.p1[1:0];
		if (h.p1 == `MIA_P1_HA)
			seq = 2'h1;
		if (h.p1 == `MIA_P1_HASH && endb) begin
			keep = acc;
			seq = 2'h2;
		end
		if (h.p1 == `MIA_P1_AAA) begin
			seq = 2'h0;
			reply(acc);
		end
		if (h.p1 == `MIA_P1_HA && endb)
			reply(mix(acc, sec));
		status(`MIA_SW1_OK, `MIA_SW2_OK);
	endtask
////////////////////////////////////////
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cmd_ready <= 1'b0;
			tx_ready <= 1'b0;
		end else begin
			cmd_ready <= !stall;
			tx_ready <= !stall;
		end
	end

	initial begin
		rsp_valid = 1'b0;
		rsp_data = 8'h00;
		sw_valid = 1'b0;
		sw1 = 8'h00;
		sw2 = 8'h00;
		bad = 0;
		blocks = 0;
		seq = 2'h0;
		chain = 2'h0;
		forever begin
			@(posedge clock);
			if (nrst && cmd_valid && cmd_ready) begin
				h = cmd;
				blocks++;
				d.delete();
				while (d.size() < h.lc) begin
					@(posedge clock);
					if (tx_valid && tx_ready)
						d.push_back(tx_data);
				end
				serve();
			end
		end
	end
endmodule

//--- verif/tb_top.sv
// self-checking bench for the ip authentication host controller
`timescale 1ns/10ps
module tb_top
	import mia_pkg::*;
;
	typedef struct packed {
		mia_opt_e opt;
		logic [7:0] slot;
		logic [15:0] len;
		mia_code_e code;
		logic slow;
	} mia_row_s;
	logic clock, nrst, job_valid, job_ready, in_valid, in_ready;
	logic out_valid, done_valid, cmd_valid, cmd_ready, tx_valid, tx_ready;
	logic rsp_valid, sw_valid, stall, force_err, fault, slow_q;
	logic [7:0] in_data, out_data, tx_data, rsp_data, sw1, sw2, keep;
	mia_job_s job;
	mia_done_s done;
	mia_cmd_s cmd;
	int num_errors, total_checks, cycles, bad, blocks;
	mia_row_s rows [16] = '{
		'{OPT_HASH, 8'h00, 16'h000A, CODE_ORDER, 1'b0},
		'{OPT_HA, 8'h03, 16'h0005, CODE_OK, 1'b0},
		'{OPT_HA, 8'h07, 16'h00FE, CODE_OK, 1'b0},
		'{OPT_AAA, 8'h04, 16'h0014, CODE_ORDER, 1'b0},
		'{OPT_HASH, 8'h00, 16'h000A, CODE_OK, 1'b0},
		'{OPT_AAA, 8'h04, 16'h0014, CODE_OK, 1'b0},
		'{OPT_HASH, 8'h00, 16'h000A, CODE_ORDER, 1'b0},
		'{OPT_HA, 8'h09, 16'h0258, CODE_OK, 1'b1},
		'{OPT_HASH, 8'h00, 16'h012C, CODE_OK, 1'b1},
		'{OPT_AAA, 8'h05, 16'h00F0, CODE_OK, 1'b0},
		'{OPT_HA, 8'h02, 16'h0001, CODE_OK, 1'b0},
		'{OPT_HASH, 8'h00, 16'h00F7, CODE_OK, 1'b0},
		'{OPT_AAA, 8'h06, 16'h00EE, CODE_OK, 1'b0},
		'{OPT_HA, 8'h0C, 16'h012C, CODE_OK, 1'b0},
		'{OPT_HASH, 8'h00, 16'h00FF, CODE_OK, 1'b0},
		'{OPT_AAA, 8'h0D, 16'h0001, CODE_OK, 1'b0}};

	mia_host i_dut (.clock, .nrst, .job_valid, .job_ready, .job, .in_valid,
		.in_ready, .in_data, .out_valid, .out_data, .done_valid, .done,
		.cmd_valid, .cmd_ready, .cmd, .tx_valid, .tx_ready, .tx_data,
		.rsp_valid, .rsp_data, .sw_valid, .sw1, .sw2);
	mia_card_model i_card (.clock, .nrst, .cmd_valid, .cmd_ready, .cmd,
		.tx_valid, .tx_ready, .tx_data, .rsp_valid, .rsp_data, .sw_valid,
		.sw1, .sw2, .stall, .force_err, .fault, .bad, .blocks);
////////////////////////////////////////
	function automatic logic [7:0] mix(logic [7:0] a, logic [7:0] b);
		return {a[6:0], a[7]} ^ b;
	endfunction

	function automatic logic [7:0] dat(int j, int k);
		return 8'(j * 29 + k * 3 + 1);
	endfunction

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_code(input mia_code_e got, input mia_code_e exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic run(input mia_row_s r, input int j);
		int n, got, eb, b0;
		logic [7:0] a, e;
		logic [15:0] sw;
		n = r.len + (r.opt == OPT_HASH ? 8 : 0);
		a = r.opt == OPT_HASH ? 8'h00 : r.slot ^ 8'h5A;
		e = 8'h00;
		if (r.opt == OPT_AAA)
			a = mix(mix(dat(j, 0), r.slot ^ 8'hA5), keep);
		for (int k = r.opt == OPT_AAA && n >= 238 ? n - 237 : 0; k < n; k++)
			a = mix(a, dat(j, k));
		if (r.opt == OPT_HA)
			e = mix(a, r.slot ^ 8'h5A);
		else if (r.opt == OPT_AAA)
			e = a;
		else if (r.code == CODE_OK)
			keep = a;
		eb = r.opt == OPT_HA ? (r.len + 253) / 254 :
			r.opt == OPT_HASH ? (r.len + 7) / 255 + 1 : 1;
		if (r.code != CODE_OK)
			eb = r.code != CODE_ORDER;
		got = 0;
		@(posedge clock);
		b0 = blocks;
		slow_q <= r.slow;
		job_valid <= 1'b1;
		job <= '{r.opt, r.slot, r.len};
		do @(negedge clock); while (job_ready !== 1'b1);
		@(posedge clock);
		job_valid <= 1'b0;
		fork
			begin
				for (int k = 0; k < n; k++) begin
					in_valid <= 1'b1;
					in_data <= dat(j, k);
					do @(negedge clock); while (in_ready !== 1'b1);
					@(posedge clock);
				end
				in_valid <= 1'b0;
			end
			do begin
				@(negedge clock);
				if (out_valid === 1'b1) begin
					chk_val(out_data, 8'(e + 8'(got)));
					got++;
				end
			end while (done_valid !== 1'b1);
		join
		n = r.code == CODE_OK && r.opt != OPT_HASH ? 16 : 0;
		sw = r.code == CODE_OK ? 16'h9000 :
			r.code == CODE_SEQ ? 16'h9834 : 16'h6F00;
		chk_code(done.code, r.code);
		chk_val(16'(got), 16'(n));
		chk_val(16'(blocks - b0), 16'(eb));
		if (r.code != CODE_ORDER)
			chk_val({done.sw1, done.sw2}, sw);
	endtask
////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles++;
		stall <= slow_q && cycles[1];
		if (cycles == 60000) begin
			num_errors++;
			conclude();
		end
	end

	initial begin
		nrst = 1'b0;
		job_valid = 1'b0;
		job = '0;
		in_valid = 1'b0;
		in_data = 8'h00;
		fault = 1'b0;
		force_err = 1'b0;
		slow_q = 1'b0;
		keep = 8'h00;
		repeat (16) @(posedge clock);
		@(negedge clock);
		chk_val(16'({job_ready, cmd_valid, tx_valid, out_valid, done_valid,
			in_ready}), 16'h0021);
		@(posedge clock);
		nrst <= 1'b1;
		foreach (rows[i]) run(rows[i], i);
		@(posedge clock);
		force_err <= 1'b1;
		run('{OPT_HA, 8'h0A, 16'h012C, CODE_SEQ, 1'b0}, 20);
		@(posedge clock);
		force_err <= 1'b0;
		run('{OPT_AAA, 8'h0A, 16'h0010, CODE_ORDER, 1'b0}, 21);
		run('{OPT_HA, 8'h0A, 16'h0030, CODE_OK, 1'b0}, 22);
		@(posedge clock);
		fault <= 1'b1;
		run('{OPT_HA, 8'h0B, 16'h0100, CODE_CARD, 1'b0}, 23);
		@(posedge clock);
		fault <= 1'b0;
		chk_val(16'(bad), 16'h0000);
		conclude();
	end
endmodule
